//--- regulator_sequence_control_cfg.svh
`ifndef REGULATOR_SEQUENCE_CONTROL_CFG_SVH
`define REGULATOR_SEQUENCE_CONTROL_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and time base
`define CLK_PERIOD_NS 5
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define VREG_SETTLE_US 50
`define VREG_SETTLE_TICKS (`VREG_SETTLE_US * 1000 / `TICK_NS)
`define SYNC_LOSS_NS 2000
`define SYNC_LOSS_CYCLES (`SYNC_LOSS_NS / `CLK_PERIOD_NS)
`define SS_COEFF_US_PER_MV 1
`define GOOD_RELEASE_TICKS 1000
`define RESET_RELEASE_TICKS 2000
`define GOOD_FILTER_TICKS 10
`define RESET_FILTER_TICKS 20

////////////////////////////////////////////////////////////////////////////////
// Register map
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_STATE 8'h08
`define REG_VOUT_BASE 8'h10
`define REG_VOUT_LAST 8'h24
`define VOUT_W 13
`define VOUT_RESET 13'h03e8

////////////////////////////////////////////////////////////////////////////////
// Status and mask bits
`define ST_OVERTEMP 0
`define ST_UVLO 1
`define ST_GOOD_LOST 2
`define ST_W 8

////////////////////////////////////////////////////////////////////////////////
// State register fields
`define SF_RUN 0
`define SF_DISCHARGE 6
`define SF_GOOD 12
`define SF_SS_BUSY 18
`define SF_CHIP_ON 24
`define SF_VREG_ON 25
`define SF_WDT_RUN 26
`define SF_SYNC_RUN 27
`define SF_OVERTEMP 28
`define SF_SUPPLY_OK 29

`endif

//--- regulator_sequence_control_pkg.sv
package regulator_sequence_control_pkg;

	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_INIT,
		SEQ_VREG_START,
		SEQ_READY
	} seq_state_t;

	// Window comparator flags of one output
	typedef struct packed {
		logic above_uv_hys;
		logic below_ov_hys;
		logic at_or_below_uv;
		logic at_or_above_ov;
	} window_t;

	typedef struct packed {
		logic [5:0] run;
		logic [5:0] discharge;
		logic [5:0] ss_busy;
		logic [3:0] lx_hiz;
	} channel_cmd_t;

endpackage : regulator_sequence_control_pkg

//--- good_monitor.sv
`timescale 1ns/1ps
module good_monitor
(
	hclk,
	hresetn,
	tick,
	run,
	win,
	release_ticks,
	filter_ticks,
	drive_low_q,
	lost_q
);
	input wire logic hclk;
	input wire logic hresetn;
	input wire logic tick;
	input wire logic run;
	input wire regulator_sequence_control_pkg::window_t win;
	input wire logic [15:0] release_ticks;
	input wire logic [15:0] filter_ticks;
	output logic drive_low_q;
	output logic lost_q;

	logic qual_q;
	logic qual_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic drive_low_d;
	wire logic bad = win.at_or_below_uv | win.at_or_above_ov;
	wire logic good = win.above_uv_hys & win.below_ov_hys;
	wire logic cnt_hit = cnt_q >= filter_ticks;

	// Hysteresis: in between both thresholds the last verdict holds
	assign qual_d = !run ? 1'b0 : bad ? 1'b0 : good ? 1'b1 : qual_q; // [RL15]

	always_comb
	begin
		cnt_d = cnt_q;
		drive_low_d = drive_low_q;
		if (!run)
		begin
			cnt_d = 16'h0000;
			drive_low_d = 1'b1;
		end
		else if (drive_low_q)
		begin
			if (!qual_q)
				cnt_d = 16'h0000;
			else if (cnt_q >= release_ticks)
			begin
				drive_low_d = 1'b0; // [RL12]
				cnt_d = 16'h0000;
			end
			else if (tick)
				cnt_d = cnt_q + 16'h0001;
		end
		else
		begin
			// Short excursions restart the filter and never reach the pin
			if (qual_q)
				cnt_d = 16'h0000; // [RL13]
			else if (cnt_hit)
			begin
				drive_low_d = 1'b1; // [RL13]
				cnt_d = 16'h0000;
			end
			else if (tick)
				cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			qual_q <= 1'b0;
			cnt_q <= 16'h0000;
			drive_low_q <= 1'b1;
			lost_q <= 1'b0;
		end
		else
		begin
			qual_q <= qual_d;
			cnt_q <= cnt_d;
			drive_low_q <= drive_low_d;
			lost_q <= run & !drive_low_q & drive_low_d;
		end
	end

endmodule : good_monitor

//--- regulator_sequence_control.sv
// Behaviour
// [RL1] All enables low: shutdown, everything off
// [RL2] Start internal supply before any channel
// [RL3] Start only with supply above upper threshold
// [RL4] Chip control, internal supply follow any enable
// [RL5] Channels, watchdog, sync follow their conditions
// [RL6] Overtemperature stops all, discharges every output; chip control and internal supply stay on
// [RL7] Overtemperature release soft-starts enabled channels
// [RL8] Buck overvoltage: stop switching, node high-Z
// [RL9] Undervoltage stops everything, resumes automatically
// [RL10] Soft-start time equals voltage times coefficient
// [RL11] Disabled channel discharges its output
// [RL12] Good output released after release delay
// [RL13] Good output falls only after filter delay
// [RL14] First linear channel drives reset output
// [RL15] Good window qualified with hysteresis
// [RL16] Open-drain outputs, delays counted as parameters
`timescale 1ns/1ps
`include "regulator_sequence_control_cfg.svh"
module regulator_sequence_control
#(
	parameter logic [15:0] GOOD_RELEASE_DELAY = 16'(`GOOD_RELEASE_TICKS),
	parameter logic [15:0] RESET_RELEASE_DELAY = 16'(`RESET_RELEASE_TICKS),
	parameter logic [15:0] GOOD_FAULT_FILTER_DELAY = 16'(`GOOD_FILTER_TICKS),
	parameter logic [15:0] RESET_FAULT_FILTER_DELAY = 16'(`RESET_FILTER_TICKS)
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic buck1_enable_pin,
	input wire logic buck2_enable_pin,
	input wire logic buck3_enable_pin,
	input wire logic buck4_enable_pin,
	input wire logic linear1_enable_pin,
	input wire logic linear2_enable_pin,
	input wire logic ext_clock_pin,
	input wire logic overtemp_shutdown,
	input wire logic supply_ok,
	input wire logic [3:0] buck_overvoltage,
	input wire regulator_sequence_control_pkg::window_t [5:0] out_window,
	output logic chip_control_on,
	output logic vreg_on,
	output logic watchdog_monitor_run,
	output logic freq_sync_run,
	output regulator_sequence_control_pkg::channel_cmd_t channel_cmd,
	output logic buck1_good_out_o,
	output logic buck1_good_out_oe,
	output logic buck2_good_out_o,
	output logic buck2_good_out_oe,
	output logic buck3_good_out_o,
	output logic buck3_good_out_oe,
	output logic buck4_good_out_o,
	output logic buck4_good_out_oe,
	output logic linear2_good_out_o,
	output logic linear2_good_out_oe,
	output logic reset_out_o,
	output logic reset_out_oe,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_vout_addr(input logic [7:0] a);
		is_vout_addr = (a >= `REG_VOUT_BASE) && (a <= `REG_VOUT_LAST) && (a[1:0] == 2'b00);
	endfunction : is_vout_addr

	function automatic logic [2:0] vout_index(input logic [7:0] a);
		logic [7:0] off;
		off = a - `REG_VOUT_BASE;
		vout_index = off[4:2];
	endfunction : vout_index

	// Ramp length in ticks: target millivolts times microseconds per millivolt
	function automatic logic [15:0] ramp_ticks(input logic [`VOUT_W-1:0] mv);
		ramp_ticks = 16'(mv) * 16'(`SS_COEFF_US_PER_MV); // [RL10]
	endfunction : ramp_ticks

	////////////////////////////////////////////////////////////////////////////////
	// Time base

	logic [7:0] div_q;
	logic tick_q;
	wire logic div_wrap = (div_q == 8'(`TICK_CYCLES - 1));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_q <= 8'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
			tick_q <= div_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sequencer

	wire logic [5:0] en = {linear2_enable_pin, linear1_enable_pin, buck4_enable_pin,
		buck3_enable_pin, buck2_enable_pin, buck1_enable_pin};
	wire logic any_en = |en;

	regulator_sequence_control_pkg::seq_state_t seq_q;
	regulator_sequence_control_pkg::seq_state_t seq_d;
	logic [15:0] settle_q;
	logic supply_ok_q;
	logic overtemp_q;

	always_comb
	begin
		seq_d = seq_q;
		unique case (seq_q)
			regulator_sequence_control_pkg::SEQ_OFF:
				if (any_en && supply_ok) // [RL3]
					seq_d = regulator_sequence_control_pkg::SEQ_INIT; // [RL2]
			regulator_sequence_control_pkg::SEQ_INIT:
				seq_d = regulator_sequence_control_pkg::SEQ_VREG_START; // [RL2]
			regulator_sequence_control_pkg::SEQ_VREG_START:
				if (settle_q >= 16'(`VREG_SETTLE_TICKS))
					seq_d = regulator_sequence_control_pkg::SEQ_READY; // [RL2]
			regulator_sequence_control_pkg::SEQ_READY:
				seq_d = seq_q;
		endcase
		// Either cause drops the whole chip, including the internal supply
		if (!any_en || !supply_ok)
			seq_d = regulator_sequence_control_pkg::SEQ_OFF; // [RL1] [RL9]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			seq_q <= regulator_sequence_control_pkg::SEQ_OFF;
			settle_q <= 16'h0000;
		end
		else
		begin
			seq_q <= seq_d;
			if (seq_q != regulator_sequence_control_pkg::SEQ_VREG_START)
				settle_q <= 16'h0000;
			else if (tick_q)
				settle_q <= settle_q + 16'h0001;
		end
	end

	wire logic ready = (seq_q == regulator_sequence_control_pkg::SEQ_READY);
	// Overtemperature is deliberately not part of this term
	wire logic chip_on_d = (seq_d != regulator_sequence_control_pkg::SEQ_OFF); // [RL4]

	////////////////////////////////////////////////////////////////////////////////
	// External clock activity

	logic ext_clock_q;
	logic [11:0] since_edge_q;
	wire logic ext_edge = ext_clock_pin ^ ext_clock_q;
	wire logic clock_alive = since_edge_q < 12'(`SYNC_LOSS_CYCLES);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_clock_q <= 1'b0;
			since_edge_q <= 12'(`SYNC_LOSS_CYCLES);
		end
		else
		begin
			ext_clock_q <= ext_clock_pin;
			if (ext_edge)
				since_edge_q <= 12'h000;
			else if (clock_alive)
				since_edge_q <= since_edge_q + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel commands

	wire logic overtemp = overtemp_shutdown;
	wire logic [5:0] run_d = (ready && chip_on_d && !overtemp) ? en : 6'h00; // [RL5] [RL6] [RL7]
	// Discharge on disable, and on every output during overtemperature while chip control is on
	wire logic [5:0] dis_d = ~en | {6{overtemp & chip_on_d}}; // [RL11] [RL6]
	// Soft-start state is kept through overvoltage, so switching resumes
	wire logic [3:0] hiz_d = ~run_d[3:0] | buck_overvoltage; // [RL8]

	logic [15:0] ramp_q [6];
	logic [5:0] ss_busy_d;
	logic [`VOUT_W-1:0] vout_q [6];

	always_comb
	begin
		for (int i = 0; i < 6; i++)
			ss_busy_d[i] = run_d[i] && (ramp_q[i] < ramp_ticks(vout_q[i])); // [RL10]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 6; i++)
				ramp_q[i] <= 16'h0000;
		end
		else
		begin
			// A stopped channel restarts its ramp from zero
			for (int i = 0; i < 6; i++)
				if (!run_d[i])
					ramp_q[i] <= 16'h0000; // [RL7]
				else if (tick_q && ss_busy_d[i])
					ramp_q[i] <= ramp_q[i] + 16'h0001; // [RL10]
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			channel_cmd <= '0;
			chip_control_on <= 1'b0;
			vreg_on <= 1'b0;
			watchdog_monitor_run <= 1'b0;
			freq_sync_run <= 1'b0;
		end
		else
		begin
			channel_cmd.run <= run_d; // [RL5]
			channel_cmd.discharge <= dis_d; // [RL11]
			channel_cmd.ss_busy <= ss_busy_d;
			channel_cmd.lx_hiz <= hiz_d; // [RL8]
			chip_control_on <= chip_on_d; // [RL4] [RL1]
			vreg_on <= chip_on_d; // [RL4] [RL9]
			watchdog_monitor_run <= run_d[4]; // [RL5] [RL9]
			freq_sync_run <= ready && !overtemp && clock_alive; // [RL5] [RL6]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Good and reset monitors

	logic [5:0] drive_low;
	logic [5:0] lost;

	for (genvar g = 0; g < 6; g++)
	begin : g_mon
		good_monitor u_mon
		(
			.hclk(hclk),
			.hresetn(hresetn),
			.tick(tick_q),
			.run(channel_cmd.run[g]),
			.win(out_window[g]),
			.release_ticks(g == 4 ? RESET_RELEASE_DELAY : GOOD_RELEASE_DELAY), // [RL14] [RL16]
			.filter_ticks(g == 4 ? RESET_FAULT_FILTER_DELAY : GOOD_FAULT_FILTER_DELAY), // [RL14]
			.drive_low_q(drive_low[g]),
			.lost_q(lost[g])
		);
	end

	// Open drain: the data level is always low, the enable pulls the pin
	logic pin_level_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pin_level_q <= 1'b0;
		else
			pin_level_q <= 1'b0; // [RL16]
	end

	assign buck1_good_out_o = pin_level_q;
	assign buck2_good_out_o = pin_level_q;
	assign buck3_good_out_o = pin_level_q;
	assign buck4_good_out_o = pin_level_q;
	assign linear2_good_out_o = pin_level_q;
	assign reset_out_o = pin_level_q;
	assign buck1_good_out_oe = drive_low[0]; // [RL16]
	assign buck2_good_out_oe = drive_low[1];
	assign buck3_good_out_oe = drive_low[2];
	assign buck4_good_out_oe = drive_low[3];
	assign reset_out_oe = drive_low[4]; // [RL14]
	assign linear2_good_out_oe = drive_low[5];

	////////////////////////////////////////////////////////////////////////////////
	// Events

	logic [`ST_W-1:0] status_q;
	logic [`ST_W-1:0] mask_q;
	wire logic [`ST_W-1:0] events = {lost, supply_ok_q & !supply_ok, overtemp & !overtemp_q};

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	logic [7:0] waddr_q;
	logic wpend_q;
	wire logic take = hsel && hready && htrans[1];
	wire logic [7:0] a = haddr[7:0];
	wire logic wr_status = wpend_q && (waddr_q == `REG_STATUS);
	wire logic [`ST_W-1:0] w1c = wr_status ? hwdata[`ST_W-1:0] : '0;
	wire logic [5:0] good_now = ~drive_low;
	wire logic [31:0] state_word = {2'b00, supply_ok, overtemp, freq_sync_run,
		watchdog_monitor_run, vreg_on, chip_control_on, channel_cmd.ss_busy,
		good_now, channel_cmd.discharge, channel_cmd.run};
	wire logic [31:0] rd_mux =
		(a == `REG_STATUS) ? 32'(status_q) :
		(a == `REG_MASK) ? 32'(mask_q) :
		(a == `REG_STATE) ? state_word :
		is_vout_addr(a) ? 32'(vout_q[vout_index(a)]) : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			waddr_q <= 8'h00;
			wpend_q <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wpend_q <= take && hwrite;
			if (take)
				waddr_q <= a;
			if (take && !hwrite)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_q <= '0;
			mask_q <= '0;
			supply_ok_q <= 1'b0;
			overtemp_q <= 1'b0;
			irq <= 1'b0;
			for (int i = 0; i < 6; i++)
				vout_q[i] <= `VOUT_RESET;
		end
		else
		begin
			supply_ok_q <= supply_ok;
			overtemp_q <= overtemp;
			// A new event in the clearing cycle stays set
			status_q <= (status_q & ~w1c) | events;
			irq <= |(((status_q & ~w1c) | events) & mask_q);
			if (wpend_q && waddr_q == `REG_MASK)
				mask_q <= hwdata[`ST_W-1:0];
			// Writes land next to the running ramp; a changed target only moves its end
			if (wpend_q && is_vout_addr(waddr_q))
				vout_q[vout_index(waddr_q)] <= hwdata[`VOUT_W-1:0];
		end
	end

endmodule : regulator_sequence_control

//--- regulator_sequence_control_chk.sv
`timescale 1ns/1ps
module regulator_sequence_control_chk
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic buck1_enable_pin,
	input wire logic buck2_enable_pin,
	input wire logic buck3_enable_pin,
	input wire logic buck4_enable_pin,
	input wire logic linear1_enable_pin,
	input wire logic linear2_enable_pin,
	input wire logic overtemp_shutdown,
	input wire logic supply_ok,
	input wire logic [3:0] buck_overvoltage,
	input wire logic chip_control_on,
	input wire logic vreg_on,
	input wire logic watchdog_monitor_run,
	input wire logic freq_sync_run,
	input wire regulator_sequence_control_pkg::channel_cmd_t channel_cmd
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic any_en;
	assign any_en = buck1_enable_pin | buck2_enable_pin | buck3_enable_pin | buck4_enable_pin
		| linear1_enable_pin | linear2_enable_pin;
	////////////////////////////////////////////////////////////////////////////////
	// Three samples span state and output register stages
	sequence s_idle;
		!any_en [*3];
	endsequence
	sequence s_hot;
		overtemp_shutdown [*3];
	endsequence
	sequence s_low_supply;
		!supply_ok [*3];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_shut_all_off: assert property (s_idle |-> !chip_control_on && !vreg_on)
		else $error("Chip on with every enable low");
	a_run_needs_vreg: assert property (channel_cmd.run != 6'h00 |-> vreg_on)
		else $error("Channel runs before internal supply");
	a_start_needs_supply: assert property ($rose(vreg_on) |-> $past(supply_ok))
		else $error("Start without supply above lockout");
	a_chip_follows_en: assert property ((any_en && supply_ok) [*4] |-> chip_control_on && vreg_on)
		else $error("Chip control off with an enable high");
	a_wdt_needs_en: assert property (!linear1_enable_pin [*3] |-> !watchdog_monitor_run)
		else $error("Watchdog monitor runs with its enable low");
	a_hot_stops_all: assert property (s_hot |-> channel_cmd.run == 6'h00 && !watchdog_monitor_run
		&& !freq_sync_run && channel_cmd.discharge == 6'h3f)
		else $error("Overtemperature did not stop and discharge");
	a_ovp_node_hiz: assert property (((buck_overvoltage & $past(buck_overvoltage))
		& ~channel_cmd.lx_hiz) == 4'h0)
		else $error("Switch node driven during overvoltage");
	a_uvlo_stops_all: assert property (s_low_supply |-> !vreg_on && !watchdog_monitor_run
		&& channel_cmd.run == 6'h00)
		else $error("Undervoltage did not stop the device");
	a_off_discharge: assert property (!buck1_enable_pin [*2] |-> channel_cmd.discharge[0])
		else $error("Disabled channel not discharged");
endmodule : regulator_sequence_control_chk
////////////////////////////////////////////////////////////////////////////////
bind regulator_sequence_control regulator_sequence_control_chk regulator_sequence_control_chk_i
(
	.hclk(hclk), .hresetn(hresetn), .buck1_enable_pin(buck1_enable_pin),
	.buck2_enable_pin(buck2_enable_pin), .buck3_enable_pin(buck3_enable_pin),
	.buck4_enable_pin(buck4_enable_pin), .linear1_enable_pin(linear1_enable_pin),
	.linear2_enable_pin(linear2_enable_pin), .overtemp_shutdown(overtemp_shutdown),
	.supply_ok(supply_ok), .buck_overvoltage(buck_overvoltage),
	.chip_control_on(chip_control_on), .vreg_on(vreg_on),
	.watchdog_monitor_run(watchdog_monitor_run), .freq_sync_run(freq_sync_run),
	.channel_cmd(channel_cmd)
);

//--- rail_model.sv
`timescale 1ns/1ps
// Output rails: rise one cycle after run, faults forced by the bench
module rail_model
(
	input wire logic hclk,
	input wire logic [5:0] run,
	input wire logic [5:0] bad,
	input wire logic [5:0] band,
	output regulator_sequence_control_pkg::window_t [5:0] win
);
	logic [5:0] up_q;
	always_ff @(posedge hclk)
		up_q <= run;
	// Band sits inside the hysteresis: neither good nor bad
	always_comb
		for (int i = 0; i < 6; i++)
		begin
			win[i].above_uv_hys = up_q[i] & !bad[i] & !band[i];
			win[i].below_ov_hys = 1'b1;
			win[i].at_or_below_uv = !up_q[i] | bad[i];
			win[i].at_or_above_ov = 1'b0;
		end
endmodule : rail_model

//--- tb_regulator_sequence_control.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("BAD %s exp %0h got %0h", n, e, g); \
		end \
	end
module tb_regulator_sequence_control;
	localparam int TK = 200;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, ext_clock_pin, overtemp_shutdown;
	logic supply_ok, chip_control_on, vreg_on, watchdog_monitor_run, freq_sync_run, sync_on;
	logic buck1_good_out_o, buck1_good_out_oe, buck2_good_out_o, buck2_good_out_oe;
	logic buck3_good_out_o, buck3_good_out_oe, buck4_good_out_o, buck4_good_out_oe;
	logic linear2_good_out_o, linear2_good_out_oe, reset_out_o, reset_out_oe;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] buck_overvoltage;
	logic [5:0] en, bad, band, r;
	logic [31:0] haddr, hwdata, hrdata, rd;
	regulator_sequence_control_pkg::window_t [5:0] out_window;
	regulator_sequence_control_pkg::channel_cmd_t channel_cmd;
	int n_fail, samples_checked, n, vout;
	regulator_sequence_control #(
		.GOOD_RELEASE_DELAY(16'h0004),
		.RESET_RELEASE_DELAY(16'h0006),
		.GOOD_FAULT_FILTER_DELAY(16'h0002),
		.RESET_FAULT_FILTER_DELAY(16'h0003)
	) regulator_sequence_control_i (
		.*,
		.hready(hreadyout),
		.buck1_enable_pin(en[0]), .buck2_enable_pin(en[1]), .buck3_enable_pin(en[2]),
		.buck4_enable_pin(en[3]), .linear1_enable_pin(en[4]), .linear2_enable_pin(en[5])
	);
	rail_model rail_model_i (.hclk(hclk), .run(channel_cmd.run), .bad(bad), .band(band),
		.win(out_window));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always
	begin
		repeat (10) @(posedge hclk);
		if (sync_on)
			ext_clock_pin <= ~ext_clock_pin;
	end
	initial
	begin
		repeat (100000) @(posedge hclk);
		n_fail++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Tick phase is free running, so allow one tick either side
	function automatic bit near(input int c, input int t);
		return (c + 10 > (t - 1) * TK) && (c <= (t + 1) * TK + 10);
	endfunction : near
	task automatic wcyc(input int c);
		repeat (c) @(posedge hclk);
	endtask : wcyc
	task automatic wait_ready();
		for (int i = 0; i < 50 && hreadyout !== 1'b1; i++)
			@(posedge hclk);
		if (hreadyout !== 1'b1)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_ready
	// Bounded wait until all six channels run
	task automatic wait_run(input int lim);
		for (int i = 0; i < lim && channel_cmd.run !== 6'h3f; i++)
			@(posedge hclk);
		if (channel_cmd.run !== 6'h3f)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_run
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		wait_ready();
		rd = hrdata;
	endtask : ahb
	task automatic ramp_check();
		int t_ss = 0;
		int t_pg = 0;
		int t_rs = 0;
		for (int i = 0; i < 20 * TK; i++)
		begin
			@(posedge hclk);
			if (channel_cmd.ss_busy[0] === 1'b1)
				t_ss = i;
			if (buck1_good_out_oe === 1'b1)
				t_pg = i;
			if (reset_out_oe === 1'b1)
				t_rs = i;
		end
		`CHK("ss_time", 1'b1, near(t_ss, vout))
		`CHK("pg_release", 1'b1, near(t_pg, 4))
		`CHK("rs_release", 1'b1, near(t_rs, 6))
		`CHK("pg_b", 3'h0, {buck3_good_out_oe, buck4_good_out_oe, linear2_good_out_oe})
		`CHK("lvl_a", 3'h0, {buck1_good_out_o, buck2_good_out_o, buck3_good_out_o})
		`CHK("lvl_b", 3'h0, {buck4_good_out_o, linear2_good_out_o, reset_out_o})
	endtask : ramp_check
	task automatic tally_and_finish();
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		ext_clock_pin = 1'b0;
		sync_on = 1'b0;
		overtemp_shutdown = 1'b0;
		supply_ok = 1'b0;
		buck_overvoltage = 4'h0;
		en = 6'h00;
		bad = 6'h00;
		band = 6'h00;
		n_fail = 0;
		samples_checked = 0;
		void'($urandom(46725));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("chip_off", 1'b0, chip_control_on)
		`CHK("rst_low", 1'b1, reset_out_oe)
		ahb(1'b0, 8'h10, 32'h0);
		`CHK("vout_rst", 32'h3e8, rd)
		ahb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		vout = 3 + $urandom % 4;
		for (n = 0; n < 6; n++)
			ahb(1'b1, 8'h10 + 8'(4 * n), 32'(vout));
		// Startup held off until supply is good, then settle time
		en <= 6'h3f;
		wcyc(20);
		`CHK("uvlo_hold", 1'b0, vreg_on)
		supply_ok <= 1'b1;
		wcyc(45 * TK);
		`CHK("vreg_first", 1'b1, vreg_on)
		`CHK("run_wait", 6'h00, channel_cmd.run)
		wait_run(10 * TK);
		`CHK("run_all", 6'h3f, channel_cmd.run)
		ramp_check();
		// Short excursion ignored, long one pulls low
		bad <= 6'h11;
		wcyc(100);
		bad <= 6'h00;
		wcyc(3 * TK);
		`CHK("glitch_pg", 1'b0, buck1_good_out_oe)
		`CHK("glitch_rs", 1'b0, reset_out_oe)
		band <= 6'h02;
		bad <= 6'h11;
		wcyc(5 * TK);
		`CHK("lost_pg", 1'b1, buck1_good_out_oe)
		`CHK("lost_rs", 1'b1, reset_out_oe)
		`CHK("band_pg", 1'b0, buck2_good_out_oe)
		ahb(1'b0, 8'h00, 32'h0);
		`CHK("lost_stat", 32'h44, rd)
		bad <= 6'h00;
		band <= 6'h00;
		ahb(1'b1, 8'h00, 32'hff);
		buck_overvoltage <= 4'h1;
		wcyc(3);
		`CHK("ov_hiz", 4'h1, channel_cmd.lx_hiz)
		`CHK("ov_run", 6'h3f, channel_cmd.run)
		buck_overvoltage <= 4'h0;
		wcyc(3);
		`CHK("ov_back", 4'h0, channel_cmd.lx_hiz)
		sync_on <= 1'b1;
		wcyc(100);
		`CHK("sync_on", 1'b1, freq_sync_run)
		sync_on <= 1'b0;
		wcyc(500);
		`CHK("sync_off", 1'b0, freq_sync_run)
		// Masked event stays silent until unmasked
		ahb(1'b1, 8'h04, 32'h0);
		overtemp_shutdown <= 1'b1;
		wcyc(5);
		`CHK("ot_run", 6'h00, channel_cmd.run)
		`CHK("ot_dis", 6'h3f, channel_cmd.discharge)
		`CHK("ot_chip", 1'b1, vreg_on)
		`CHK("ot_masked", 1'b0, irq)
		// Chip and supply on, all discharging, nothing good or running
		ahb(1'b0, 8'h08, 32'h0);
		`CHK("ot_state", 32'h3300_0fc0, rd)
		ahb(1'b1, 8'h04, 32'hff);
		wcyc(2);
		`CHK("ot_irq", 1'b1, irq)
		ahb(1'b1, 8'h00, 32'h1);
		wcyc(2);
		`CHK("ot_clear", 1'b0, irq)
		overtemp_shutdown <= 1'b0;
		wait_run(10);
		`CHK("ot_resume", 6'h3f, channel_cmd.run)
		ramp_check();
		// One channel kept on so the sequencer never drops to off
		for (n = 0; n < 3; n++)
		begin
			r = 6'($urandom) | 6'h20;
			en <= r;
			wcyc(5);
			`CHK("rnd_run", r, channel_cmd.run)
			`CHK("rnd_dis", ~r, channel_cmd.discharge)
			`CHK("rnd_wdt", r[4], watchdog_monitor_run)
		end
		supply_ok <= 1'b0;
		en <= 6'h3f;
		wcyc(5);
		`CHK("uv_vreg", 1'b0, vreg_on)
		`CHK("uv_run", 6'h00, channel_cmd.run)
		ahb(1'b0, 8'h00, 32'h0);
		`CHK("uv_stat", 32'h2, rd & 32'h2)
		supply_ok <= 1'b1;
		wait_run(60 * TK);
		`CHK("uv_resume", 6'h3f, channel_cmd.run)
		en <= 6'h00;
		wcyc(5);
		`CHK("all_off", 1'b0, vreg_on)
		`CHK("all_dis", 6'h3f, channel_cmd.discharge)
		tally_and_finish();
	end
endmodule : tb_regulator_sequence_control
